// ### core/pulse_count_led_current_ctrl.v
// Overview of operation
// RULE1: main and sub 4-bit level registers
// RULE2: 17 edges addresses both levels together
// RULE3: 18 edges main only, 19 sub only
// RULE4: 20 edges addresses full-scale register
// RULE5: 21 edges addresses low-current pattern
// RULE6: scale 1,2,3 pick 20,30,15mA tables
// RULE7: scale 4 means low-current pattern only
// RULE8: pattern decodes off, sub, main, both
// RULE9: unwritten scale defaults to 20mA table
// RULE10: scale change keeps stored level values
// RULE11: data burst of 1-16 edges stored
// RULE12: host sends address, pause, data, pause
// RULE13: host writes scale 4 then pattern
// RULE14: load switch until sink nears dropout
// RULE15: over-temperature disables the pump
// RULE16: latch count after pin high timeout
// RULE17: long low pin enters shutdown
// RULE18: shutdown sets every register to 1
// RULE19: after shutdown address 1 is selected
// RULE20: bursts over 21 edges are ignored
// RULE21: data writes hit selected register only
`timescale 1ns/1ps
`include "pulse_count_led_current_ctrl_defs.vh"

module pulse_count_led_current_ctrl
#(
   parameter LATCH_CYC = `LATCH_TIMEOUT_CYC,
   parameter OFF_CYC = `OFF_TIMEOUT_CYC,
   parameter PUMP_DIV = `PUMP_DIV_CYC
)
(
   input wire clk,
   input wire reset,
   input wire ctrl_pin,
   input wire [3:0] sink_near_dropout,
   input wire over_temp,
   output reg shutdown_ff,
   output reg [3:0] main_level_ff,
   output reg [3:0] sub_level_ff,
   output reg [3:0] scale_ff,
   output reg [3:0] pattern_ff,
   output reg main_low_mode_ff,
   output reg sub_low_mode_ff,
   output reg [1:0] main_fs_ff,
   output reg [1:0] sub_fs_ff,
   output reg [3:0] main_code_ff,
   output reg [3:0] sub_code_ff,
   output reg [1:0] pump_mode_ff,
   output reg pump_clk_en_ff
);

   // =====================================================
   // pin edge detection and timers
   reg pin_d_ff;
   reg [4:0] edge_cnt_ff;
   reg cnt_ovf_ff;
   reg [31:0] high_cnt_ff;
   reg [31:0] low_cnt_ff;
   reg [4:0] addr_ff;
   wire rise;
   wire latch_now;
   wire off_now;

   assign rise = ctrl_pin & ~pin_d_ff;
   // latch fires once, the cycle the high time reaches the timeout
   assign latch_now = ctrl_pin & (high_cnt_ff == LATCH_CYC - 1) & (edge_cnt_ff != 5'h00); // [RULE16]
   assign off_now = ~ctrl_pin & (low_cnt_ff == OFF_CYC - 1) & ~shutdown_ff; // [RULE17]

   always @(posedge clk)
   begin
      if (reset)
      begin
         // pin idles high, so a high pin leaving reset is no edge
         pin_d_ff <= 1'b1;
         high_cnt_ff <= 32'h0000_0000;
         low_cnt_ff <= 32'h0000_0000;
      end
      else
      begin
         pin_d_ff <= ctrl_pin;
         if (ctrl_pin)
         begin
            low_cnt_ff <= 32'h0000_0000;
            if (rise)
               high_cnt_ff <= 32'h0000_0000;
            else if (high_cnt_ff < LATCH_CYC)
               high_cnt_ff <= high_cnt_ff + 32'h0000_0001;
         end
         else
         begin
            high_cnt_ff <= 32'h0000_0000;
            if (low_cnt_ff < OFF_CYC)
               low_cnt_ff <= low_cnt_ff + 32'h0000_0001;
         end
      end
   end

   // =====================================================
   // edge counter and register writes
   always @(posedge clk)
   begin
      if (reset | off_now)
      begin
         edge_cnt_ff <= 5'h00;
         cnt_ovf_ff <= 1'b0;
         shutdown_ff <= 1'b1;
         addr_ff <= `ADDR_BOTH; // [RULE19]
         main_level_ff <= `REG_RESET; // [RULE18]
         sub_level_ff <= `REG_RESET; // [RULE18]
         scale_ff <= `REG_RESET; // [RULE9] [RULE18]
         pattern_ff <= `REG_RESET; // [RULE18]
      end
      else
      begin
         if (rise)
         begin
            shutdown_ff <= 1'b0;
            // saturate: beyond 21 the burst is marked invalid
            if (edge_cnt_ff == `ADDR_LOW)
               cnt_ovf_ff <= 1'b1; // [RULE20]
            else
               edge_cnt_ff <= edge_cnt_ff + 5'h01;
         end
         else if (latch_now)
         begin
            edge_cnt_ff <= 5'h00;
            cnt_ovf_ff <= 1'b0;
            if (!cnt_ovf_ff) // [RULE20]
            begin
               if (edge_cnt_ff > `DATA_MAX)
                  addr_ff <= edge_cnt_ff; // [RULE2] [RULE3] [RULE4] [RULE5]
               else
               begin
                  // address persists across data writes
                  case (addr_ff) // [RULE21]
                     `ADDR_BOTH:
                     begin
                        main_level_ff <= edge_cnt_ff[3:0]; // [RULE2] [RULE11]
                        sub_level_ff <= edge_cnt_ff[3:0]; // [RULE2]
                     end
                     `ADDR_MAIN: main_level_ff <= edge_cnt_ff[3:0]; // [RULE3] [RULE1]
                     `ADDR_SUB: sub_level_ff <= edge_cnt_ff[3:0]; // [RULE3] [RULE1]
                     `ADDR_SCALE: scale_ff <= edge_cnt_ff[3:0]; // [RULE4]
                     `ADDR_LOW: pattern_ff <= edge_cnt_ff[3:0]; // [RULE5]
                     default: main_level_ff <= main_level_ff;
                  endcase
               end
            end
         end
      end
   end

   // =====================================================
   // current code decode
   reg [1:0] nxt_main_fs;
   reg [1:0] nxt_sub_fs;
   reg [3:0] nxt_main_code;
   reg [3:0] nxt_sub_code;
   reg nxt_main_low;
   reg nxt_sub_low;
   reg [3:0] pm1;

   always @*
   begin
      pm1 = pattern_ff - 4'h1;
      nxt_main_low = 1'b0;
      nxt_sub_low = 1'b0;
      // level codes index the selected table, levels kept on scale change
      nxt_main_code = main_level_ff; // [RULE10]
      nxt_sub_code = sub_level_ff; // [RULE10]
      case (scale_ff) // [RULE6]
         `SCALE_20MA:
         begin
            nxt_main_fs = `FS_20MA;
            nxt_sub_fs = `FS_20MA;
         end
         `SCALE_30MA:
         begin
            nxt_main_fs = `FS_30MA;
            nxt_sub_fs = `FS_30MA;
         end
         `SCALE_15MA:
         begin
            nxt_main_fs = `FS_15MA;
            nxt_sub_fs = `FS_15MA;
         end
         `SCALE_LOW:
         begin
            // levels ignored; code is step 0..3 = 0.05,0.5,1,2 mA
            nxt_main_fs = `FS_OFF; // [RULE7]
            nxt_sub_fs = `FS_OFF;
            nxt_main_code = {2'b00, pm1[1:0]};
            nxt_sub_code = {2'b00, pm1[1:0]};
            nxt_sub_low = (pm1[3:2] == 2'b01) | (pm1[3:2] == 2'b11); // [RULE8]
            nxt_main_low = pm1[3]; // [RULE8]
         end
         default:
         begin
            // unused scale codes treated as the default table
            nxt_main_fs = `FS_20MA; // [RULE9]
            nxt_sub_fs = `FS_20MA;
         end
      endcase
   end

   // =====================================================
   // switching tick, about 1 MHz from the 40 MHz clock
   reg [15:0] div_ff;
   wire pump_tick;

   assign pump_tick = (div_ff == PUMP_DIV - 1);

   always @(posedge clk)
   begin
      if (reset | pump_tick)
      begin
         div_ff <= 16'h0000;
      end
      else
      begin
         div_ff <= div_ff + 16'h0001;
      end
   end

   // =====================================================
   // pump mode
   reg [1:0] nxt_pump;
   wire any_dropout;
   wire pump_block;

   assign any_dropout = |sink_near_dropout; // [RULE14]
   // a hot die or a shut down part forces the pump off; a tick in its first cycle still enables from the old mode
   assign pump_block = over_temp | shutdown_ff; // [RULE15]

   always @*
   begin
      if (pump_block)
      begin
         nxt_pump = `PUMP_OFF; // [RULE15]
      end
      else if (!any_dropout)
      begin
         nxt_pump = `PUMP_1X; // [RULE14]
      end
      else if ((pump_mode_ff == `PUMP_1P5X) | (pump_mode_ff == `PUMP_2X))
      begin
         // still near dropout at 1.5x, so double; 2x holds until it clears
         nxt_pump = `PUMP_2X; // [RULE14]
      end
      else
      begin
         // leaving the load switch always starts at 1.5x
         nxt_pump = `PUMP_1P5X; // [RULE14]
      end
   end

   always @(posedge clk)
   begin
      if (reset)
      begin
         pump_clk_en_ff <= 1'b0;
         pump_mode_ff <= `PUMP_OFF;
      end
      else
      begin
         pump_clk_en_ff <= 1'b0;
         if (pump_tick)
         begin
            pump_clk_en_ff <= (pump_mode_ff == `PUMP_1P5X) | (pump_mode_ff == `PUMP_2X);
            // step the pump decision at the switching rate to avoid chatter
            pump_mode_ff <= nxt_pump;
         end
         else if (pump_block)
         begin
            pump_mode_ff <= `PUMP_OFF; // [RULE15]
         end
      end
   end

   // =====================================================
   // registered current codes
   always @(posedge clk)
   begin
      if (reset)
      begin
         main_fs_ff <= `FS_OFF;
         sub_fs_ff <= `FS_OFF;
         main_code_ff <= 4'h0;
         sub_code_ff <= 4'h0;
         main_low_mode_ff <= 1'b0;
         sub_low_mode_ff <= 1'b0;
      end
      else
      begin
         main_fs_ff <= nxt_main_fs;
         sub_fs_ff <= nxt_sub_fs;
         main_code_ff <= nxt_main_code;
         sub_code_ff <= nxt_sub_code;
         main_low_mode_ff <= nxt_main_low;
         sub_low_mode_ff <= nxt_sub_low;
      end
   end

endmodule

// ### core/pulse_count_led_current_ctrl_defs.vh
`ifndef PULSE_COUNT_LED_CURRENT_CTRL_DEFS_VH
`define PULSE_COUNT_LED_CURRENT_CTRL_DEFS_VH

// timing: latch and off timeouts in ns, cycles at 40 MHz (25 ns)
`define CLK_PERIOD_NS 25
`define LATCH_TIMEOUT_NS 500
`define LATCH_TIMEOUT_CYC ((`LATCH_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFF_TIMEOUT_NS 500000
`define OFF_TIMEOUT_CYC ((`OFF_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// pump clock divider, about 1 MHz from 40 MHz
`define PUMP_DIV_CYC 40

// address edge counts
`define ADDR_BOTH 5'h11
`define ADDR_MAIN 5'h12
`define ADDR_SUB 5'h13
`define ADDR_SCALE 5'h14
`define ADDR_LOW 5'h15
`define DATA_MAX 5'h10

// register reset value and scale codes
`define REG_RESET 4'h1
`define SCALE_20MA 4'h1
`define SCALE_30MA 4'h2
`define SCALE_15MA 4'h3
`define SCALE_LOW 4'h4

// output scale encodings
`define FS_OFF 2'h0
`define FS_20MA 2'h1
`define FS_30MA 2'h2
`define FS_15MA 2'h3
`define PUMP_1X 2'h0
`define PUMP_1P5X 2'h1
`define PUMP_2X 2'h2
`define PUMP_OFF 2'h3

`endif

// ### tb/host_model.sv
`timescale 1ns/1ps
// ========
// host side of the single control pin, idle high
module host_model
#(
   parameter LATCH_CYC = 4
)
(
   input wire clk,
   output reg ctrl_pin
);
   initial ctrl_pin = 1'b1;
   // one low and one high cycle per rise, then a high pause past the latch timeout
   task burst(input integer n);
      integer k;
      begin
         for (k = 0; k < n; k = k + 1)
         begin
            @(posedge clk) #2 ctrl_pin = 1'b0;
            @(posedge clk) #2 ctrl_pin = 1'b1;
         end
         repeat (LATCH_CYC + 5) @(posedge clk);
         #2;
      end
   endtask
   task write(input integer a, input integer d);
      begin
         burst(a);
         burst(d);
      end
   endtask
   task low(input integer n);
      begin
         @(posedge clk) #2 ctrl_pin = 1'b0;
         repeat (n) @(posedge clk);
         #2;
      end
   endtask
endmodule

// ### tb/pulse_ctrl_assertions.sv
`timescale 1ns/1ps
// ========
// port checker for the pulse count control block
module pulse_ctrl_chk
#(
   parameter LATCH_CYC = 4,
   parameter OFF_CYC = 50
)
(
   input wire clk,
   input wire reset,
   input wire ctrl_pin,
   input wire over_temp,
   input wire shutdown_ff,
   input wire [3:0] main_level_ff,
   input wire [3:0] sub_level_ff,
   input wire [3:0] scale_ff,
   input wire [3:0] pattern_ff,
   input wire main_low_mode_ff,
   input wire sub_low_mode_ff,
   input wire [1:0] main_fs_ff,
   input wire [3:0] main_code_ff,
   input wire [1:0] pump_mode_ff
);
   reg [7:0] hi_cnt_ff;
   reg [15:0] lo_cnt_ff;
   wire all_one = {main_level_ff, sub_level_ff, scale_ff, pattern_ff} == 16'h1111;
   // pattern minus one: top bits pick the groups, low bits the step
   wire [3:0] pm1 = pattern_ff - 4'h1;
   wire [1:0] lo_grp = pm1[3:2];
   wire [3:0] lo_step = {2'h0, pm1[1:0]};
   // saturating run lengths, so long idle stretches cannot wrap
   always @(posedge clk)
   begin
      hi_cnt_ff <= (reset || !ctrl_pin) ? 8'h00 : hi_cnt_ff + {7'h00, hi_cnt_ff != 8'hff};
      lo_cnt_ff <= (reset || ctrl_pin) ? 16'h0000 : lo_cnt_ff + {15'h0000, lo_cnt_ff != 16'hffff};
   end
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (reset);
   a_reset_all_one: assert property ($fell(reset) |-> shutdown_ff && all_one)
      else $error("registers not one after reset");
   a_off_shutdown: assert property (lo_cnt_ff == OFF_CYC + 2 |-> shutdown_ff && all_one)
      else $error("no shutdown after long low pin");
   a_latch_wait: assert property ($changed(main_level_ff) && ctrl_pin |-> hi_cnt_ff >= LATCH_CYC)
      else $error("level changed before latch timeout");
   a_scale_table: assert property (scale_ff == 4'h2 || scale_ff == 4'h3 |=> main_fs_ff == $past(scale_ff))
      else $error("wrong full scale table");
   a_default_table: assert property (!(scale_ff inside {4'h2, 4'h3, 4'h4}) |=> main_fs_ff == 2'h1)
      else $error("default table not used");
   a_level_code: assert property (scale_ff != 4'h4 |=> main_code_ff == $past(main_level_ff))
      else $error("main code does not follow level");
   a_low_groups: assert property (scale_ff == 4'h4 |=> main_fs_ff == 2'h0
      && {main_low_mode_ff, sub_low_mode_ff} == $past(lo_grp)) else $error("low groups wrong");
   a_low_step: assert property (scale_ff == 4'h4 && pm1[3] |=> main_code_ff == $past(lo_step))
      else $error("low step wrong");
   a_heat_stop: assert property (over_temp [*3] |-> pump_mode_ff == 2'h3)
      else $error("pump runs while hot");
   a_pump_step: assert property (pump_mode_ff == 2'h0 |=> pump_mode_ff != 2'h2)
      else $error("pump skipped the 1.5x step");
   c_low_main: cover property (scale_ff == 4'h4 && main_low_mode_ff);
   c_shutdown: cover property ($rose(shutdown_ff));
   c_scale_30: cover property (main_fs_ff == 2'h2);
   c_pump_2x: cover property (pump_mode_ff == 2'h2);
endmodule

bind pulse_count_led_current_ctrl pulse_ctrl_chk #(.LATCH_CYC(LATCH_CYC), .OFF_CYC(OFF_CYC)) chk_i (
   .clk(clk), .reset(reset), .ctrl_pin(ctrl_pin), .over_temp(over_temp), .shutdown_ff(shutdown_ff),
   .main_level_ff(main_level_ff), .sub_level_ff(sub_level_ff), .scale_ff(scale_ff),
   .pattern_ff(pattern_ff), .main_low_mode_ff(main_low_mode_ff), .sub_low_mode_ff(sub_low_mode_ff),
   .main_fs_ff(main_fs_ff), .main_code_ff(main_code_ff), .pump_mode_ff(pump_mode_ff));

// ### tb/tb_top.sv
`timescale 1ns/1ps
// ========
// bench top
module tb_top;
   localparam LAT = 4;
   localparam OFF = 50;
   reg clk;
   reg reset = 1'b1;
   reg over_temp = 1'b0;
   reg [3:0] sink_near_dropout = 4'h0;
   wire ctrl_pin, shutdown_ff, main_low_mode_ff, sub_low_mode_ff, pump_clk_en_ff;
   wire [3:0] main_level_ff, sub_level_ff, scale_ff, pattern_ff, main_code_ff, sub_code_ff;
   wire [1:0] main_fs_ff, sub_fs_ff, pump_mode_ff;
   wire [16:0] st_v = {shutdown_ff, main_level_ff, sub_level_ff, scale_ff, pattern_ff};
   wire [11:0] dec_v = {main_fs_ff, sub_fs_ff, main_code_ff, sub_code_ff};
   integer fail_count = 0;
   integer checked = 0;
   integer cyc = 0;
   integer i;
   reg [3:0] s;
   host_model #(.LATCH_CYC(LAT)) host (.clk(clk), .ctrl_pin(ctrl_pin));
   pulse_count_led_current_ctrl #(.LATCH_CYC(LAT), .OFF_CYC(OFF), .PUMP_DIV(8)) dut (
      .clk(clk), .reset(reset), .ctrl_pin(ctrl_pin), .sink_near_dropout(sink_near_dropout),
      .over_temp(over_temp), .shutdown_ff(shutdown_ff), .main_level_ff(main_level_ff),
      .sub_level_ff(sub_level_ff), .scale_ff(scale_ff), .pattern_ff(pattern_ff),
      .main_low_mode_ff(main_low_mode_ff), .sub_low_mode_ff(sub_low_mode_ff),
      .main_fs_ff(main_fs_ff), .sub_fs_ff(sub_fs_ff), .main_code_ff(main_code_ff),
      .sub_code_ff(sub_code_ff), .pump_mode_ff(pump_mode_ff), .pump_clk_en_ff(pump_clk_en_ff));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task chk(input [19:0] got, input [19:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp)
         begin
            fail_count = fail_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task close_out;
      begin
         $display("comparisons %0d mismatches %0d", checked, fail_count);
         if (fail_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // count switching ticks over two divider periods
   task ticks(input integer exp);
      integer n;
      begin
         n = 0;
         repeat (16)
         begin
            @(posedge clk);
            #2;
            n = n + pump_clk_en_ff;
         end
         chk(n, exp);
      end
   endtask
   // a hung burst would otherwise stall the run forever
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         fail_count = fail_count + 1;
         close_out;
      end
   end
   initial
   begin
      repeat (16) @(posedge clk);
      #2 reset = 1'b0;
      repeat (2) @(posedge clk);
      #2;
      chk(st_v, 17'h1_1111);
      chk(dec_v, 12'h511);
      $display("test reset done");
      host.write(18, 9);
      chk(st_v, 17'h0_9111);
      host.write(19, 16);
      chk(st_v, 17'h0_9011);
      chk(dec_v, 12'h590);
      host.burst(3);
      chk(st_v, 17'h0_9311);
      host.write(17, 7);
      chk(st_v, 17'h0_7711);
      host.burst(22);
      chk(st_v, 17'h0_7711);
      host.burst(2);
      chk(st_v, 17'h0_2211);
      $display("test levels done");
      for (i = 1; i < 4; i = i + 1)
      begin
         s = 4'((i % 3) + 1);
         host.write(20, s);
         chk(st_v, {9'h022, s, 4'h1});
         chk(dec_v, {s[1:0], s[1:0], 8'h22});
      end
      $display("test scale done");
      host.write(20, 4);
      for (i = 0; i < 4; i = i + 1)
      begin
         host.write(21, 5 * i + 1);
         chk(st_v, {13'h0224, 4'(5 * i + 1)});
         chk({main_low_mode_ff, sub_low_mode_ff, main_fs_ff, sub_fs_ff}, {i[1:0], 4'h0});
         if (i > 1)
            chk(main_code_ff, i[3:0]);
      end
      $display("test low current done");
      sink_near_dropout = 4'h2;
      repeat (40) @(posedge clk);
      #2;
      chk(pump_mode_ff, 2'h2);
      ticks(2);
      over_temp = 1'b1;
      repeat (4) @(posedge clk);
      #2;
      chk(pump_mode_ff, 2'h3);
      ticks(0);
      over_temp = 1'b0;
      sink_near_dropout = 4'h0;
      repeat (40) @(posedge clk);
      #2;
      chk(pump_mode_ff, 2'h0);
      ticks(0);
      $display("test pump done");
      host.low(OFF + 5);
      chk(st_v, 17'h1_1111);
      host.burst(5);
      chk(st_v, 17'h0_5511);
      chk(dec_v, 12'h555);
      $display("test shutdown done");
      close_out;
   end
endmodule
